// ===== logic/dual_timer_counter_unit.sv
`timescale 1ns/10ps
module dual_timer_counter_unit
(
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    input  wire timer_pkg::apb_req_type apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  event_pin_a,
    input  wire logic                  event_pin_b,
    input  wire logic                  ext_irq_pin_a,
    input  wire logic                  ext_irq_pin_b,
    output logic                       chan0_irq,
    output logic                       chan1_irq,
    output logic                       serial_tick,
    output logic                       machine_tick
);
    import timer_pkg::*;

    // ------------------------------------------------------------
    // machine cycle phase
    // ------------------------------------------------------------
    logic [3:0] phase_q;
    logic [3:0] phase_d;
    wire        cycle_end = (phase_q == 4'(CYCLE_DIV - 1));
    wire        sample_pt = (phase_q == 4'(SAMPLE_PHASE));

    assign phase_d = cycle_end ? 4'h0 : phase_q + 4'h1;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    wire  [3:0] pins_raw = {ext_irq_pin_b, ext_irq_pin_a, event_pin_b, event_pin_a};

    // ------------------------------------------------------------
    // event sampling: one sample per machine cycle
    // ------------------------------------------------------------
    logic [1:0] sample_q;
    logic [1:0] prev_q;
    logic [1:0] fall_q;
    logic [1:0] fall_d;

    // a fall seen at this cycle's sample is counted at the next cycle end
    assign fall_d = sample_pt ? (prev_q & ~sample_q) : fall_q;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] mode_q;
    logic       run0_q;
    logic       run1_q;
    logic       flag0_q;
    logic       flag1_q;
    logic [7:0] c0l_q;
    logic [7:0] c0h_q;
    logic [7:0] c1l_q;
    logic [7:0] c1h_q;

    chan_cfg_type cfg0;
    chan_cfg_type cfg1;
    assign cfg0 = mode_q[3:0];
    assign cfg1 = mode_q[7:4];

    // ------------------------------------------------------------
    // count enables
    // ------------------------------------------------------------
    wire src0 = cfg0.counter_sel ? fall_q[0] : 1'b1;
    wire src1 = cfg1.counter_sel ? fall_q[1] : 1'b1;
    // gate pins only gate; irq detection elsewhere still sees the raw pins
    wire en0  = run0_q && (!cfg0.gate || sync_q[2]) && src0 && cycle_end;
    wire en1  = run1_q && (!cfg1.gate || sync_q[3]) && src1 && cycle_end
                && (cfg1.mode != MODE_SPLIT) && (cfg1.mode != MODE_RELOAD);
    wire split0 = (cfg0.mode == MODE_SPLIT);
    wire enh0 = split0 && run1_q && cycle_end;

    // ------------------------------------------------------------
    // channel next-state
    // ------------------------------------------------------------
    logic [7:0] c0l_n;
    logic [7:0] c0h_n;
    logic [7:0] c1l_n;
    logic [7:0] c1h_n;
    logic       ovf0;
    logic       ovf1;
    logic       ovfh0;

    function automatic logic [16:0] step
    (
        input logic [1:0] mode,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [16:0] r;
        r = {1'b0, hi, lo};
        case (mode)
            2'b00:
            begin
                // upper low-byte bits just carry along, left undefined for software
                if (lo[4:0] == 5'h1F)
                begin
                    r = {(hi == 8'hFF), hi + 8'h01, lo[7:5], 5'h00};
                end
                else
                begin
                    r = {1'b0, hi, lo + 8'h01};
                end
            end
            2'b01:
            begin
                r = {1'b0, hi, lo} + 17'h00001;
            end
            2'b10:
            begin
                r = (lo == 8'hFF) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
            end
            default:
            begin
                r = (lo == 8'hFF) ? {1'b1, hi, 8'h00} : {1'b0, hi, lo + 8'h01};
            end
        endcase
        return r;
    endfunction

    wire [16:0] s0 = step(cfg0.mode, c0l_q, c0h_q);
    wire [16:0] s1 = step(cfg1.mode, c1l_q, c1h_q);

    assign ovf0  = en0 & s0[16];
    assign ovf1  = en1 & s1[16];
    assign ovfh0 = enh0 & (c0h_q == 8'hFF);
    assign c1l_n = en1 ? s1[7:0] : c1l_q;
    assign c1h_n = en1 ? s1[15:8] : c1h_q;
    assign c0l_n = en0 ? s0[7:0] : c0l_q;
    // in split mode the high byte is its own cycle counter
    assign c0h_n = split0 ? (enh0 ? c0h_q + 8'h01 : c0h_q) : (en0 ? s0[15:8] : c0h_q);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire        acc   = apb_req.psel && apb_req.penable;
    wire        wr    = acc && apb_req.pwrite;
    wire [7:0]  wd    = apb_req.pwdata[7:0];
    wire        hit_mode = (apb_req.paddr == ADDR_MODE);
    wire        hit_ctrl = (apb_req.paddr == ADDR_CTRL);
    wire        hit_c0l  = (apb_req.paddr == ADDR_C0_LOW);
    wire        hit_c0h  = (apb_req.paddr == ADDR_C0_HIGH);
    wire        hit_c1l  = (apb_req.paddr == ADDR_C1_LOW);
    wire        hit_c1h  = (apb_req.paddr == ADDR_C1_HIGH);
    wire        hit_ack  = (apb_req.paddr == ADDR_ACK);
    wire        mapped   = hit_mode | hit_ctrl | hit_c0l | hit_c0h | hit_c1l | hit_c1h | hit_ack;
    wire [7:0]  ctrl_rd  = {flag1_q, run1_q, flag0_q, run0_q, 4'h0};
    wire [7:0]  rd_byte  = hit_mode ? mode_q :
                           hit_ctrl ? ctrl_rd :
                           hit_c0l  ? c0l_q :
                           hit_c0h  ? c0h_q :
                           hit_c1l  ? c1l_q :
                           hit_c1h  ? c1h_q : 8'h00;

    // vector acknowledge: bit 0 channel 0, bit 1 channel 1
    wire        ack0 = wr && hit_ack && wd[0];
    wire        ack1 = wr && hit_ack && wd[1];
    wire        set0 = ovf0;
    wire        set1 = ovf1 | (split0 & ovfh0);
    wire        ov1_serial = ovf1;
    // overflow wins over a same-cycle clear so no event is lost
    wire        flag0_d = set0 | ((wr && hit_ctrl ? wd[CTRL_FLAG0_BIT] : flag0_q) & ~ack0);
    wire        flag1_d = set1 | ((wr && hit_ctrl ? wd[CTRL_FLAG1_BIT] : flag1_q) & ~ack1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            phase_q      <= 4'h0;
            meta_q       <= 4'h0;
            sync_q       <= 4'h0;
            sample_q     <= 2'h0;
            prev_q       <= 2'h0;
            fall_q       <= 2'h0;
            mode_q       <= MODE_RESET;
            run0_q       <= 1'b0;
            run1_q       <= 1'b0;
            flag0_q      <= 1'b0;
            flag1_q      <= 1'b0;
            c0l_q        <= BYTE_RESET;
            c0h_q        <= BYTE_RESET;
            c1l_q        <= BYTE_RESET;
            c1h_q        <= BYTE_RESET;
            prdata       <= 32'h00000000;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            chan0_irq    <= 1'b0;
            chan1_irq    <= 1'b0;
            serial_tick  <= 1'b0;
            machine_tick <= 1'b0;
        end
        else
        begin
            phase_q  <= phase_d;
            meta_q   <= pins_raw;
            sync_q   <= meta_q;
            if (sample_pt)
            begin
                sample_q <= sync_q[1:0];
                prev_q   <= sample_q;
            end
            // one-shot per machine cycle: consumed at cycle end
            fall_q   <= cycle_end ? 2'h0 : fall_d;
            // software writes land on the access edge, i.e. end of the instruction
            mode_q   <= (wr && hit_mode) ? wd : mode_q;
            if (wr && hit_ctrl)
            begin
                run0_q <= wd[CTRL_RUN0_BIT];
                run1_q <= wd[CTRL_RUN1_BIT];
            end
            flag0_q  <= flag0_d;
            flag1_q  <= flag1_d;
            c0l_q    <= (wr && hit_c0l) ? wd : c0l_n;
            c0h_q    <= (wr && hit_c0h) ? wd : c0h_n;
            c1l_q    <= (wr && hit_c1l) ? wd : c1l_n;
            c1h_q    <= (wr && hit_c1h) ? wd : c1h_n;
            pready   <= apb_req.psel && !apb_req.penable && !pready;
            pslverr  <= apb_req.psel && !apb_req.penable && !mapped;
            prdata   <= (apb_req.psel && !apb_req.penable) ? {24'h000000, rd_byte} : prdata;
            chan0_irq    <= flag0_d;
            chan1_irq    <= flag1_d;
            serial_tick  <= ov1_serial;
            machine_tick <= cycle_end;
        end
    end

endmodule

// ===== logic/timer_pkg.sv
// Overview of operation
// - timer function advances count once per machine cycle, oscillator over twelve.
// - counter function samples event pin each machine cycle, counts high-then-low.
// - count updated by detection appears in the following machine cycle.
// - recognising a falling transition takes two machine cycles, max rate osc/24.
// - mode 0 is 13 bits: high byte plus low five bits of low byte.
// - count only while run bit set and gating off or interrupt pin high.
// - setting run bit leaves the count registers unchanged.
// - mode 1 equals mode 0 but uses all sixteen bits.
// - mode 2 low byte counts, reloads from high byte on overflow, flags.
// - channel 0 mode 3 low byte uses channel 0 controls and flag.
// - channel 0 mode 3 high byte counts cycles on channel 1 run, flag.
// - each channel 1 overflow sends one pulse to the serial port.
// - channel 1 mode 2 is reserved; no auto-reload needed there.
// - channel 1 in mode 3 stops its counting.
// - gated counting leaves interrupt pin detection independent.
// - counters wrap from all ones, set overflow flag, raise interrupt request.
// - mode and control writes take effect at end of writing instruction.
// - event pins sampled at fixed points of each machine cycle.
// - counter increments fourteen oscillator periods after sampled falling transition.
// - mode bits 00,01,10,11 select modes 0..3; 01 is cascaded 16-bit.
// - overflow flag cleared by hardware on interrupt vector.
// - counter-select low picks machine cycles, high picks event pin.
package timer_pkg;

    localparam int          CYCLE_DIV        = 12;
    localparam int          SAMPLE_PHASE     = 9;
    localparam logic [11:0] ADDR_MODE        = 12'h000;
    localparam logic [11:0] ADDR_CTRL        = 12'h004;
    localparam logic [11:0] ADDR_C0_LOW      = 12'h008;
    localparam logic [11:0] ADDR_C0_HIGH     = 12'h00C;
    localparam logic [11:0] ADDR_C1_LOW      = 12'h010;
    localparam logic [11:0] ADDR_C1_HIGH     = 12'h014;
    localparam logic [11:0] ADDR_ACK         = 12'h018;
    localparam logic [7:0]  MODE_RESET       = 8'h00;
    localparam logic [7:0]  BYTE_RESET       = 8'h00;
    localparam int          CTRL_RUN0_BIT    = 4;
    localparam int          CTRL_FLAG0_BIT   = 5;
    localparam int          CTRL_RUN1_BIT    = 6;
    localparam int          CTRL_FLAG1_BIT   = 7;

    typedef enum logic [1:0]
    {
        MODE_13BIT  = 2'b00,
        MODE_16BIT  = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT  = 2'b11
    } mode_type;

    typedef struct packed
    {
        logic     gate;
        logic     counter_sel;
        mode_type mode;
    } chan_cfg_type;

    typedef struct packed
    {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

endpackage

// ===== verification/event_source.sv
`timescale 1ns/10ps
module event_source
(
    input wire logic ref_clk,
    output logic     pin
);
    // idle high, like a pulled-up port pin between bursts
    initial pin = 1'b1;

    task automatic burst(input int n, input int half);
        repeat (n)
        begin
            repeat (half) @(posedge ref_clk);
            pin <= 1'b0;
            repeat (half) @(posedge ref_clk);
            pin <= 1'b1;
        end
    endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import timer_pkg::*;
    logic        ref_clk, reset_n, gate_a, gate_b, ev_a, ev_b;
    logic        pready, pslverr, chan0_irq, chan1_irq, serial_tick, machine_tick;
    apb_req_type req;
    logic [31:0] prdata, rdat;
    logic [7:0]  cv [4];
    logic [16:0] e0, e1;
    logic [15:0] v0, v1;
    int          err_count, num_checks, seed, sc, k;

    dual_timer_counter_unit u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_pin_a(ev_a),
        .event_pin_b(ev_b), .ext_irq_pin_a(gate_a), .ext_irq_pin_b(gate_b),
        .chan0_irq(chan0_irq), .chan1_irq(chan1_irq), .serial_tick(serial_tick),
        .machine_tick(machine_tick));
    event_source u_ea (.ref_clk(ref_clk), .pin(ev_a));
    event_source u_eb (.ref_clk(ref_clk), .pin(ev_b));

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (serial_tick === 1'b1) sc <= sc + 1;

    function automatic logic [16:0] nx(input logic [15:0] v, input int n);
        return 17'(v) + 17'(n);
    endfunction

    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask

    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic e);
        req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rdat = prdata;
        chk("pslverr", 16'(e), 16'(pslverr));
        req <= '0;
        @(posedge ref_clk);
    endtask

    // the control write is placed just after a machine tick so no increment races it
    task tst(input logic [7:0] md, ct, input logic [15:0] a, b, input int n, p,
             input logic [15:0] ea, eb, input logic [1:0] ef, input int es);
        int s0;
        apb(1, ADDR_MODE, md, 0);
        apb(1, ADDR_C0_LOW, a[7:0], 0);
        apb(1, ADDR_C0_HIGH, a[15:8], 0);
        apb(1, ADDR_C1_LOW, b[7:0], 0);
        apb(1, ADDR_C1_HIGH, b[15:8], 0);
        s0 = sc;
        @(posedge ref_clk iff machine_tick);
        apb(1, ADDR_CTRL, ct, 0);
        fork
            u_ea.burst(p, 16);
            u_eb.burst(p, 40);
        join
        repeat (n) @(posedge ref_clk iff machine_tick);
        repeat (2) @(posedge ref_clk);
        chk("flags", 16'(ef), {14'h0, chan1_irq, chan0_irq});
        apb(1, ADDR_ACK, 8'h03, 0);
        chk("ack", 16'h0000, {14'h0, chan1_irq, chan0_irq});
        apb(1, ADDR_CTRL, 8'h00, 0);
        for (int i = 0; i < 4; i++)
        begin
            apb(0, 12'(ADDR_C0_LOW + 4 * i), 8'h00, 0);
            cv[i] = rdat[7:0];
        end
        chk("chan0", ea, {cv[1], cv[0]});
        chk("chan1", eb, {cv[3], cv[2]});
        chk("serial", 16'(es), 16'(sc - s0));
    endtask

    initial
    begin
        seed = 77019;
        req = '0;
        reset_n = 1'b0;
        gate_a = 1'b1;
        gate_b = 1'b1;
        err_count = 0;
        num_checks = 0;
        sc = 0;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 6; i++)
        begin
            apb(0, 12'(4 * i), 8'h00, 0);
            chk("reset", 16'h0000, rdat[15:0]);
        end
        apb(0, 12'h01C, 8'h00, 1);
        apb(1, 12'h020, 8'hFF, 1);
        v0 = 16'($random(seed));
        apb(1, ADDR_MODE, v0[7:0], 0);
        apb(0, ADDR_MODE, 8'h00, 0);
        chk("mode", {8'h00, v0[7:0]}, rdat[15:0]);
        tst(8'h01, 8'h10, 16'hFFFE, 16'h4321, 3, 0, 16'h0001, 16'h4321, 2'b01, 0);
        tst(8'h00, 8'h10, 16'hFFFF, 16'h0000, 1, 0, 16'h00E0, 16'h0000, 2'b01, 0);
        tst(8'h02, 8'h10, 16'hA5FF, 16'h0000, 2, 0, 16'hA5A6, 16'h0000, 2'b01, 0);
        tst(8'h01, 8'h00, 16'h1234, 16'h0000, 3, 0, 16'h1234, 16'h0000, 2'b00, 0);
        tst(8'h10, 8'h40, 16'h0000, 16'hFFFF, 2, 0, 16'h0000, 16'h0001, 2'b10, 1);
        tst(8'h20, 8'h40, 16'h0000, 16'h1234, 2, 0, 16'h0000, 16'h1234, 2'b00, 0);
        tst(8'h33, 8'h40, 16'hFF10, 16'h2222, 2, 0, 16'h0110, 16'h2222, 2'b10, 0);
        tst(8'h33, 8'h10, 16'h00FE, 16'h2222, 3, 0, 16'h0001, 16'h2222, 2'b01, 0);
        tst(8'h55, 8'h50, 16'h0010, 16'h0020, 2, 3, 16'h0013, 16'h0023, 2'b00, 0);
        gate_a <= 1'b0;
        tst(8'h99, 8'h50, 16'h1234, 16'h5678, 3, 0, 16'h1234, 16'h567B, 2'b00, 0);
        gate_a <= 1'b1;
        gate_b <= 1'b0;
        tst(8'h99, 8'h50, 16'h1234, 16'h5678, 3, 0, 16'h1237, 16'h5678, 2'b00, 0);
        gate_b <= 1'b1;
        for (int j = 0; j < 4; j++)
        begin
            v0 = 16'($random(seed));
            v1 = 16'($random(seed));
            k = 1 + ($random(seed) & 3);
            e0 = nx(v0, k);
            e1 = nx(v1, k);
            tst(8'h11, 8'h50, v0, v1, k, 0, e0[15:0], e1[15:0], {e1[16], e0[16]}, 32'(e1[16]));
        end
        end_of_test;
    end

    initial
    begin
        #1500000;
        err_count++;
        end_of_test;
    end
endmodule

// ===== verification/timer_props.sv
`timescale 1ns/10ps
module timer_props
(
    input wire logic                   ref_clk,
    input wire logic                   reset_n,
    input wire timer_pkg::apb_req_type apb_req,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   chan0_irq,
    input wire logic                   chan1_irq,
    input wire logic                   serial_tick,
    input wire logic                   machine_tick
);
    import timer_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire wr_done = apb_req.psel & apb_req.penable & apb_req.pwrite;
    sequence setup_s; apb_req.psel && !apb_req.penable; endsequence
    sequence gap_s; !machine_tick [*8] ##1 !machine_tick [*3]; endsequence
    answer_next_a: assert property (setup_s |=> pready)
        else $error("no ready after setup");
    ready_once_a: assert property (pready |=> !pready) else $error("ready held");
    err_ready_a: assert property (pslverr |-> pready && prdata == 0)
        else $error("error without ready");
    unmapped_err_a: assert property (setup_s ##0 (apb_req.paddr > ADDR_ACK) |=> pslverr)
        else $error("unmapped not refused");
    mapped_ok_a: assert property (setup_s ##0 (apb_req.paddr[1:0] == 2'b00
        && apb_req.paddr <= ADDR_ACK) |=> !pslverr) else $error("mapped refused");
    byte_data_a: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data");
    tick_period_a: assert property (machine_tick |=> gap_s ##1 machine_tick)
        else $error("machine cycle not twelve");
    serial_flag_a: assert property (serial_tick |-> ##[0:1] chan1_irq)
        else $error("serial pulse without flag");
    flag_clear_a: assert property ($fell(chan0_irq) || $fell(chan1_irq) |-> $past(wr_done))
        else $error("flag cleared without write");
    flag_set_a: assert property ($rose(chan0_irq) |-> machine_tick
        || $past(wr_done)) else $error("flag off cycle");
endmodule

bind dual_timer_counter_unit timer_props u_props (.ref_clk(ref_clk), .reset_n(reset_n),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan0_irq(chan0_irq), .chan1_irq(chan1_irq), .serial_tick(serial_tick),
    .machine_tick(machine_tick));
